// ===== hdl/label_gen_pkg.sv
// constants for the request label generator
package label_gen_pkg;
    localparam int PART_W = 16;
    localparam int GROUP_W = 8;
    localparam logic [PART_W-1:0] DEFAULT_PART = 16'h0000;
    localparam logic [GROUP_W-1:0] DEFAULT_GROUP = 8'h00;
    localparam logic [PART_W-1:0] PART_MAX_RST = 16'h00FF;
    localparam logic [GROUP_W-1:0] GROUP_MAX_RST = 8'hFF;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_LABEL = 12'h004;
    localparam logic [11:0] ADDR_PE_ID = 12'h008;
    localparam logic [11:0] ADDR_COMP_ID = 12'h00C;
    localparam logic [11:0] ADDR_COMP_SID = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ERRDEF_BIT = 1;
    localparam int CTRL_VIRT_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/partition_label_gen.sv
// request label generator with an AXI4-Lite register slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module partition_label_gen
    import label_gen_pkg::*;
(
    input  wire logic               clk_sys,        // system clock
    input  wire logic               nrst,           // async reset, active low
    input  wire logic               reqValid,       // requester request valid
    output logic                    reqReady,       // request taken
    input  wire logic [31:0]        reqAddr,        // requester address
    input  wire logic               reqSecure,      // requester in secure state
    input  wire logic               reqVirtual,     // virtual space requested
    output logic                    dnValid,        // downstream request valid
    input  wire logic               dnReady,        // downstream accepts
    output logic [31:0]             dnAddr,         // downstream address
    output logic [PART_W-1:0]       partition_id,   // label identifier
    output logic [GROUP_W-1:0]      monitor_group,  // label group
    output logic                    space_nonsecure_flag, // label space
    output logic                    dnVirtual,      // label in virtual space
    input  wire logic [11:0]        awaddr,         // write address
    input  wire logic               awvalid,        // write address valid
    output logic                    awready,        // write address ready
    input  wire logic [31:0]        wdata,          // write data
    input  wire logic [3:0]         wstrb,          // write strobes
    input  wire logic               wvalid,         // write data valid
    output logic                    wready,         // write data ready
    output logic [1:0]              bresp,          // write response
    output logic                    bvalid,         // write response valid
    input  wire logic               bready,         // write response ready
    input  wire logic [11:0]        araddr,         // read address
    input  wire logic               arvalid,        // read address valid
    output logic                    arready,        // read address ready
    output logic [31:0]             rdata,          // read data
    output logic [1:0]              rresp,          // read response
    output logic                    rvalid,         // read valid
    input  wire logic               rready          // read ready
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [2:0]          ctrl_ff;
    logic [PART_W-1:0]   labPart_ff;
    logic [GROUP_W-1:0]  labGroup_ff;
    logic [PART_W-1:0]   partMax_ff;
    logic [GROUP_W-1:0]  groupMax_ff;
    logic [1:0]          errSeen_ff;
    logic                awHave_ff;
    logic                wHave_ff;
    logic [11:0]         awAddr_ff;
    logic [31:0]         wData_ff;
    logic [3:0]          wStrb_ff;

    // ************************************************************
    // label generation
    // ************************************************************
    wire genEnable = ctrl_ff[CTRL_EN_BIT];
    wire errDefault = ctrl_ff[CTRL_ERRDEF_BIT];
    wire virtOn = ctrl_ff[CTRL_VIRT_BIT] & reqVirtual;
    wire partErr = labPart_ff > partMax_ff;
    wire groupErr = labGroup_ff > groupMax_ff;
    wire partDef = ~genEnable | (partErr & errDefault);
    wire groupDef = ~genEnable | (errDefault & (partErr | groupErr));
    wire [PART_W-1:0] nxt_part = partDef ? DEFAULT_PART : labPart_ff;
    wire [GROUP_W-1:0] nxt_group = groupDef ? DEFAULT_GROUP : labGroup_ff;
    wire nxt_ns = ~reqSecure;
    wire slotFree = ~dnValid | dnReady;
    wire take = reqValid & slotFree;

    assign reqReady = slotFree;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dnValid <= 1'b0;
        end else if (slotFree) begin
            dnValid <= reqValid;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dnAddr <= 32'h0000_0000;
        end else if (take) begin
            dnAddr <= reqAddr;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            partition_id <= DEFAULT_PART;
        end else if (take) begin
            partition_id <= nxt_part;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            monitor_group <= DEFAULT_GROUP;
        end else if (take) begin
            monitor_group <= nxt_group;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            space_nonsecure_flag <= 1'b0;
        end else if (take) begin
            space_nonsecure_flag <= nxt_ns;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dnVirtual <= 1'b0;
        end else if (take) begin
            dnVirtual <= virtOn;
        end
    end

    // ************************************************************
    // register slave
    // ************************************************************
    wire awTake = awvalid & awready;
    wire wTake = wvalid & wready;
    wire [11:0] wrAddr = awHave_ff ? awAddr_ff : awaddr;
    wire [31:0] wrData = wHave_ff ? wData_ff : wdata;
    wire [3:0] wrStrb = wHave_ff ? wStrb_ff : wstrb;
    wire wrGo = (awHave_ff | awTake) & (wHave_ff | wTake) & ~bvalid;
    wire wrCtrl = wrGo & (wrAddr == ADDR_CTRL) & wrStrb[0];
    wire wrLab = wrGo & (wrAddr == ADDR_LABEL);
    wire wrPeId = wrGo & (wrAddr == ADDR_PE_ID);
    wire wrStat = wrGo & (wrAddr == ADDR_STATUS) & wrStrb[0];
    wire wrHit = (wrAddr == ADDR_CTRL) | (wrAddr == ADDR_LABEL) |
                 (wrAddr == ADDR_PE_ID) | (wrAddr == ADDR_STATUS);
    wire [1:0] errClr = wrStat ? wrData[1:0] : 2'h0;
    wire [1:0] errSet = take ? {groupErr, partErr} : 2'h0;
    wire [31:0] rdMux =
        (araddr == ADDR_CTRL)     ? {29'h0, ctrl_ff} :
        (araddr == ADDR_LABEL)    ? {8'h00, labGroup_ff, labPart_ff} :
        (araddr == ADDR_PE_ID)    ? {8'h00, groupMax_ff, partMax_ff} :
        (araddr == ADDR_COMP_ID)  ? {16'h0000, partMax_ff} :
        (araddr == ADDR_COMP_SID) ? {16'h0000, partMax_ff} :
        (araddr == ADDR_STATUS)   ? {30'h0, errSeen_ff} : 32'h0000_0000;
    wire rdHit = (araddr <= ADDR_STATUS) & (araddr[1:0] == 2'h0);

    // ************************************************************
    // write channels
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            awready <= 1'b0;
        end else begin
            awready <= ~awHave_ff & ~awTake & ~bvalid;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wready <= 1'b0;
        end else begin
            wready <= ~wHave_ff & ~wTake & ~bvalid;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            awHave_ff <= 1'b0;
            awAddr_ff <= 12'h000;
        end else if (awTake & ~wrGo) begin
            awHave_ff <= 1'b1;
            awAddr_ff <= awaddr;
        end else if (wrGo) begin
            awHave_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wHave_ff <= 1'b0;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
        end else if (wTake & ~wrGo) begin
            wHave_ff <= 1'b1;
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
        end else if (wrGo) begin
            wHave_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wrGo) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // register file
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= 3'h0;
        end else if (wrCtrl) begin
            ctrl_ff <= wrData[2:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            labPart_ff <= DEFAULT_PART;
        end else begin
            if (wrLab & wrStrb[0]) labPart_ff[7:0] <= wrData[7:0];
            if (wrLab & wrStrb[1]) labPart_ff[15:8] <= wrData[15:8];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            labGroup_ff <= DEFAULT_GROUP;
        end else if (wrLab & wrStrb[2]) begin
            labGroup_ff <= wrData[23:16];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            partMax_ff <= PART_MAX_RST;
        end else begin
            if (wrPeId & wrStrb[0]) partMax_ff[7:0] <= wrData[7:0];
            if (wrPeId & wrStrb[1]) partMax_ff[15:8] <= wrData[15:8];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            groupMax_ff <= GROUP_MAX_RST;
        end else if (wrPeId & wrStrb[2]) begin
            groupMax_ff <= wrData[23:16];
        end
    end

    // ************************************************************
    // status
    // ************************************************************
    // sticky error bits: set wins over clear
    logic [1:0] errNext;
    assign errNext = (errSeen_ff & ~errClr) | errSet;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            errSeen_ff <= 2'h0;
        end else begin
            errSeen_ff <= errNext;
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    wire arTake = arvalid & arready;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b0;
        end else begin
            arready <= ~rvalid & ~arTake;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rvalid <= 1'b0;
        end else if (arTake) begin
            rvalid <= 1'b1;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arTake) begin
            rdata <= rdMux;
            rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end
    end
endmodule // partition_label_gen

// ===== verification/label_gen_asserts.sv
// assertion checker for the request label generator
`timescale 1ns/10ps
module label_gen_asserts
    import label_gen_pkg::*;
(
    input wire logic clk_sys, nrst, reqValid, reqReady, reqSecure, reqVirtual, // request
    input wire logic [31:0] reqAddr, dnAddr, rdata,                 // addresses, read data
    input wire logic dnValid, dnReady, space_nonsecure_flag, dnVirtual, // downstream
    input wire logic [PART_W-1:0] partition_id,                     // label identifier
    input wire logic [GROUP_W-1:0] monitor_group,                   // label group
    input wire logic arvalid, arready, rvalid, rready               // read channels
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_take; reqValid && reqReady; endsequence
    sequence s_stall; dnValid && !dnReady; endsequence
    property p_hold;
        s_stall |=> dnValid && $stable({dnAddr, partition_id, monitor_group,
            space_nonsecure_flag, dnVirtual});
    endproperty
    property p_refuse; s_stall |-> !reqReady; endproperty
    property p_take; s_take |=> dnValid && dnAddr == $past(reqAddr); endproperty
    property p_space; s_take |=> space_nonsecure_flag == !$past(reqSecure); endproperty
    property p_virt; s_take ##0 !reqVirtual |=> !dnVirtual; endproperty
    property p_drop; dnValid && dnReady && !reqValid |=> !dnValid; endproperty
    property p_rans; arvalid && arready |=> rvalid; endproperty
    property p_rdone; rvalid && rready |=> !rvalid; endproperty
    a_hold: assert property (p_hold)
        else $error("label moved while stalled");
    a_refuse: assert property (p_refuse)
        else $error("request taken while stalled");
    a_take: assert property (p_take)
        else $error("request not forwarded");
    a_space: assert property (p_space)
        else $error("wrong space flag");
    a_virt: assert property (p_virt)
        else $error("virtual space without request");
    a_drop: assert property (p_drop)
        else $error("valid stuck after accept");
    a_rans: assert property (p_rans)
        else $error("read answer late");
    a_rdone: assert property (p_rdone)
        else $error("read valid stuck");
endmodule // label_gen_asserts

bind partition_label_gen label_gen_asserts label_gen_asserts_inst (.*);

// ===== verification/downstream_model.sv
// downstream consumer model with prompt and stalling acceptance
`timescale 1ns/10ps
module downstream_model (
    input  wire logic clk_sys, // system clock
    input  wire logic nrst,    // async reset, active low
    input  wire logic dnValid, // labeled request offered
    input  wire logic slow,    // stall most cycles
    output logic      dnReady  // request accepted
);
    logic [1:0] stall_ff;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) stall_ff <= 2'h0;
        else stall_ff <= stall_ff + 2'h1;
    end
    // ready every cycle, or one cycle in four when slow
    assign dnReady = !slow || (stall_ff == 2'h3);
endmodule // downstream_model

// ===== verification/tb.sv
// testbench for the request label generator
`timescale 1ns/10ps
module tb;
    import label_gen_pkg::*;
    logic clk_sys = 0, nrst = 0, reqValid = 0, reqSecure = 0, reqVirtual = 0, slow = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] reqAddr = '0, wdata = '0, rd, dnAddr, rdata;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] rs, bresp, rresp;
    logic reqReady, dnValid, dnReady, space_nonsecure_flag, dnVirtual;
    logic awready, wready, bvalid, arready, rvalid;
    logic [PART_W-1:0] partition_id;
    logic [GROUP_W-1:0] monitor_group;
    int failures = 0, n_checks = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    partition_label_gen partition_label_gen_inst (.*);
    downstream_model downstream_model_inst (.*);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic aw = 1, w = 1;
        @(posedge clk_sys);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (aw || w) begin
            @(posedge clk_sys);
            if (aw && awready) begin aw = 0; awvalid <= 0; end
            if (w && wready) begin w = 0; wvalid <= 0; end
        end
        while (!bvalid) @(posedge clk_sys);
        bready <= 0;
        check(32'(bresp), 32'(RESP_OKAY));
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 0;
        do @(posedge clk_sys); while (!rvalid);
        d = rdata; r = rresp; rready <= 0;
    endtask
    // expected word: virtual at 25, space at 24, group 23:16, identifier 15:0
    task automatic req(input logic s, input logic v, input logic [31:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reqValid <= 1; reqSecure <= s; reqVirtual <= v; reqAddr <= a;
        do @(posedge clk_sys); while (!reqReady);
        reqValid <= 0;
        do @(posedge clk_sys); while (!(dnValid && dnReady));
        check(dnAddr, a);
        check({6'h00, dnVirtual, space_nonsecure_flag, monitor_group, partition_id}, e);
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            stop_test;
        end
    end
    task automatic t_ident;
        axr(ADDR_COMP_ID, rd, rs);
        check(32'(rd[15:0]), 32'(PART_MAX_RST));
        check(32'(rs), 32'(RESP_OKAY));
        axr(ADDR_COMP_SID, rd, rs);
        check(32'(rd[15:0]), 32'(PART_MAX_RST));
        axr(12'h100, rd, rs);
        check(32'(rs), 32'(RESP_SLVERR));
        check(rd, 32'h0000_0000);
    endtask
    task automatic t_disabled;
        axw(ADDR_LABEL, 32'h0012_0034);
        axw(ADDR_CTRL, 32'h0000_0000);
        req(1, 0, 32'h0000_00A0, 32'h0000_0000);
        req(0, 0, 32'h0000_00A4, 32'h0100_0000);
    endtask
    task automatic t_enabled;
        slow <= 1;
        axw(ADDR_CTRL, 32'h0000_0001);
        req(0, 1, 32'h0000_00A8, 32'h0112_0034);
        axw(ADDR_CTRL, 32'h0000_0005);
        req(1, 1, 32'h0000_00AC, 32'h0212_0034);
    endtask
    // identifier above maximum: default on error, then value kept
    task automatic t_part_err;
        axw(ADDR_LABEL, 32'h0077_0100);
        axw(ADDR_CTRL, 32'h0000_0003);
        req(0, 0, 32'h0000_00B0, 32'h0100_0000);
        axr(ADDR_STATUS, rd, rs);
        check(rd, 32'h0000_0001);
        axw(ADDR_STATUS, 32'h0000_0003);
        axr(ADDR_STATUS, rd, rs);
        check(rd, 32'h0000_0000);
        axw(ADDR_CTRL, 32'h0000_0001);
        req(0, 0, 32'h0000_00B4, 32'h0177_0100);
    endtask
    // group above maximum alone, then a group-only byte write
    task automatic t_group_err;
        axw(ADDR_STATUS, 32'h0000_0003);
        axw(ADDR_PE_ID, 32'h0010_00FF);
        axr(ADDR_PE_ID, rd, rs);
        check(rd, 32'h0010_00FF);
        axw(ADDR_LABEL, 32'h0077_0005);
        axw(ADDR_CTRL, 32'h0000_0003);
        req(1, 0, 32'h0000_00B8, 32'h0000_0005);
        axr(ADDR_STATUS, rd, rs);
        check(rd, 32'h0000_0002);
        wstrb <= 4'h4;
        axw(ADDR_LABEL, 32'h0033_FFFF);
        wstrb <= 4'hF;
        axr(ADDR_LABEL, rd, rs);
        check(rd, 32'h0033_0005);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1;
        t_ident;
        t_disabled;
        t_enabled;
        t_part_err;
        t_group_err;
        stop_test;
    end
endmodule // tb
